// ### inc/fto_pkg.sv
// constants for the fan thermal override and acoustic smoothing stage
// assumes one 8-bit register port and 8-bit temperatures and duties
package fto_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SMOOTH_FLOOR = 8'h62;
  localparam logic [7:0] ADDR_SMOOTH_23 = 8'h63;
  localparam logic [7:0] ADDR_CRIT_R1 = 8'h6A;
  localparam logic [7:0] ADDR_CRIT_LOC = 8'h6B;
  localparam logic [7:0] ADDR_CRIT_R2 = 8'h6C;
  localparam logic [7:0] ADDR_HYST_R1_LOC = 8'h6D;
  localparam logic [7:0] ADDR_HYST_R2 = 8'h6E;
  localparam logic [7:0] ADDR_POLICY_STATUS = 8'h71;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SMOOTH_FLOOR = 8'h00;
  localparam logic [7:0] RST_SMOOTH_23 = 8'h00;
  localparam logic [7:0] RST_CRIT_LIMIT = 8'h64;
  localparam logic [3:0] RST_HYST = 4'h4;

  // ==========================================================
  // field positions
  localparam int FLOOR_OUT1_BIT = 5;
  localparam int FLOOR_OUT2_BIT = 6;
  localparam int FLOOR_OUT3_BIT = 7;
  localparam int SMOOTH_EN1_BIT = 3;
  localparam int SMOOTH_EN2_BIT = 7;
  localparam int SMOOTH_EN3_BIT = 3;
  localparam int STEP_CODE1_LSB = 0;
  localparam int STEP_CODE2_LSB = 4;
  localparam int STEP_CODE3_LSB = 0;
  localparam int HYST_HI_LSB = 4;
  localparam int HYST_LO_LSB = 0;

  // ==========================================================
  // thermal and duty constants
  localparam logic [7:0] CRIT_RELEASE_HYST = 8'h04;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF = 8'h00;

  // smoothing step sizes in slots of 255, by 3-bit code
  localparam logic [7:0] STEP_C0 = 8'h01;
  localparam logic [7:0] STEP_C1 = 8'h02;
  localparam logic [7:0] STEP_C2 = 8'h03;
  localparam logic [7:0] STEP_C3 = 8'h05;
  localparam logic [7:0] STEP_C4 = 8'h08;
  localparam logic [7:0] STEP_C5 = 8'h0C;
  localparam logic [7:0] STEP_C6 = 8'h18;
  localparam logic [7:0] STEP_C7 = 8'h30;

  // temperature channel selects
  localparam logic [1:0] CHAN_REMOTE1 = 2'h0;
  localparam logic [1:0] CHAN_LOCAL = 2'h1;
  localparam logic [1:0] CHAN_REMOTE2 = 2'h2;

endpackage

// ### design/fto_policy.sv
// fan control policy stage: critical override, turn-off hysteresis,
// below-start floor and per-output acoustic smoothing of three drives
// assumes temperatures, start temps, minimum and target duties come
// from the measurement and slope logic, synchronous to ref_clk
// a channel select of 3 is read as remote 1
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module fto_policy (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_local,
  input wire logic [7:0] temp_remote2,
  input wire logic [7:0] start_temp_remote1,
  input wire logic [7:0] start_temp_local,
  input wire logic [7:0] start_temp_remote2,
  input wire logic [1:0] chan_sel_1,
  input wire logic [1:0] chan_sel_2,
  input wire logic [1:0] chan_sel_3,
  input wire logic [7:0] minimum_fan_duty_1,
  input wire logic [7:0] minimum_fan_duty_2,
  input wire logic [7:0] minimum_fan_duty_3,
  input wire logic [7:0] target_duty_1,
  input wire logic [7:0] target_duty_2,
  input wire logic [7:0] target_duty_3,
  input wire logic duty_update,
  output logic [7:0] fan_drive_1,
  output logic [7:0] fan_drive_2,
  output logic [7:0] fan_drive_3,
  output logic override_active
);

  // ==========================================================
  // helper functions
  function automatic logic [7:0] step_size(input logic [2:0] code);
    logic [7:0] s;
    s = fto_pkg::STEP_C0;
    case (code)
      3'h0: s = fto_pkg::STEP_C0;
      3'h1: s = fto_pkg::STEP_C1;
      3'h2: s = fto_pkg::STEP_C2;
      3'h3: s = fto_pkg::STEP_C3;
      3'h4: s = fto_pkg::STEP_C4;
      3'h5: s = fto_pkg::STEP_C5;
      3'h6: s = fto_pkg::STEP_C6;
      default: s = fto_pkg::STEP_C7;
    endcase
    return s;
  endfunction

  // one step toward target, clamped so it never passes it
  function automatic logic [7:0] step_toward(
    input logic [7:0] cur,
    input logic [7:0] tgt,
    input logic [7:0] step
  );
    logic [7:0] r;
    r = cur;
    if (tgt > cur) begin
      if ((tgt - cur) > step) begin
        r = cur + step;
      end else begin
        r = tgt;
      end
    end else if (tgt < cur) begin
      if ((cur - tgt) > step) begin
        r = cur - step;
      end else begin
        r = tgt;
      end
    end
    return r;
  endfunction

  // true when temp is strictly below (ref - margin); 9-bit so a small
  // ref never wraps into a huge threshold
  function automatic logic below_by(
    input logic [7:0] temp,
    input logic [7:0] ref_t,
    input logic [7:0] margin
  );
    return ({1'b0, temp} + {1'b0, margin}) < {1'b0, ref_t};
  endfunction

  // maps a channel select onto the arrays; code 3 has no channel
  // of its own and falls back to remote 1 instead of running off
  function automatic logic [1:0] chan_index(input logic [1:0] code);
    logic [1:0] c;
    c = fto_pkg::CHAN_REMOTE1;
    case (code)
      fto_pkg::CHAN_REMOTE1: c = fto_pkg::CHAN_REMOTE1;
      fto_pkg::CHAN_LOCAL: c = fto_pkg::CHAN_LOCAL;
      fto_pkg::CHAN_REMOTE2: c = fto_pkg::CHAN_REMOTE2;
      default: c = fto_pkg::CHAN_REMOTE1;
    endcase
    return c;
  endfunction

  // ==========================================================
  // registers
  logic [7:0] smoothing_and_floor_config;
  logic [7:0] smooth_cfg_23;
  logic [7:0] crit_limit [3];
  logic [3:0] hyst [3];
  logic [7:0] next_smoothing_and_floor_config;
  logic [7:0] next_smooth_cfg_23;
  logic [7:0] next_crit_limit [3];
  logic [3:0] next_hyst [3];
  logic [7:0] next_reg_rdata;
  logic [2:0] crit_flag;
  logic [2:0] running;

  always_comb begin
    next_smoothing_and_floor_config = smoothing_and_floor_config;
    next_smooth_cfg_23 = smooth_cfg_23;
    next_crit_limit = crit_limit;
    next_hyst = hyst;
    next_reg_rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        fto_pkg::ADDR_SMOOTH_FLOOR: next_smoothing_and_floor_config =
          reg_wdata;
        fto_pkg::ADDR_SMOOTH_23: next_smooth_cfg_23 = reg_wdata;
        fto_pkg::ADDR_CRIT_R1: next_crit_limit[0] = reg_wdata;
        fto_pkg::ADDR_CRIT_LOC: next_crit_limit[1] = reg_wdata;
        fto_pkg::ADDR_CRIT_R2: next_crit_limit[2] = reg_wdata;
        fto_pkg::ADDR_HYST_R1_LOC: begin
          next_hyst[0] = reg_wdata[fto_pkg::HYST_HI_LSB +: 4];
          next_hyst[1] = reg_wdata[fto_pkg::HYST_LO_LSB +: 4];
        end
        fto_pkg::ADDR_HYST_R2: next_hyst[2] =
          reg_wdata[fto_pkg::HYST_HI_LSB +: 4];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        fto_pkg::ADDR_SMOOTH_FLOOR: next_reg_rdata =
          smoothing_and_floor_config;
        fto_pkg::ADDR_SMOOTH_23: next_reg_rdata = smooth_cfg_23;
        fto_pkg::ADDR_CRIT_R1: next_reg_rdata = crit_limit[0];
        fto_pkg::ADDR_CRIT_LOC: next_reg_rdata = crit_limit[1];
        fto_pkg::ADDR_CRIT_R2: next_reg_rdata = crit_limit[2];
        fto_pkg::ADDR_HYST_R1_LOC: next_reg_rdata = {hyst[0], hyst[1]};
        fto_pkg::ADDR_HYST_R2: next_reg_rdata = {hyst[2], 4'h0};
        fto_pkg::ADDR_POLICY_STATUS: next_reg_rdata =
          {1'b0, running, crit_flag, override_active};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      smoothing_and_floor_config <= fto_pkg::RST_SMOOTH_FLOOR;
      smooth_cfg_23 <= fto_pkg::RST_SMOOTH_23;
      for (int i = 0; i < 3; i++) begin
        crit_limit[i] <= fto_pkg::RST_CRIT_LIMIT;
        hyst[i] <= fto_pkg::RST_HYST;
      end
      reg_rdata <= 8'h00;
    end else begin
      smoothing_and_floor_config <= next_smoothing_and_floor_config;
      smooth_cfg_23 <= next_smooth_cfg_23;
      crit_limit <= next_crit_limit;
      hyst <= next_hyst;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================
  // per-output configuration views
  logic [7:0] temp_ch [3];
  logic [7:0] start_ch [3];
  logic [1:0] sel [3];
  logic [7:0] min_duty [3];
  logic [7:0] target [3];
  logic [2:0] floor_sel;
  logic [2:0] smooth_en;
  logic [2:0] step_code [3];

  always_comb begin
    temp_ch[0] = temp_remote1;
    temp_ch[1] = temp_local;
    temp_ch[2] = temp_remote2;
    start_ch[0] = start_temp_remote1;
    start_ch[1] = start_temp_local;
    start_ch[2] = start_temp_remote2;
    // code 3 would index past the arrays, so it is folded onto remote 1
    sel[0] = chan_index(chan_sel_1);
    sel[1] = chan_index(chan_sel_2);
    sel[2] = chan_index(chan_sel_3);
    min_duty[0] = minimum_fan_duty_1;
    min_duty[1] = minimum_fan_duty_2;
    min_duty[2] = minimum_fan_duty_3;
    target[0] = target_duty_1;
    target[1] = target_duty_2;
    target[2] = target_duty_3;
    floor_sel[0] = smoothing_and_floor_config[fto_pkg::FLOOR_OUT1_BIT];
    floor_sel[1] = smoothing_and_floor_config[fto_pkg::FLOOR_OUT2_BIT];
    floor_sel[2] = smoothing_and_floor_config[fto_pkg::FLOOR_OUT3_BIT];
    smooth_en[0] = smoothing_and_floor_config[fto_pkg::SMOOTH_EN1_BIT];
    smooth_en[1] = smooth_cfg_23[fto_pkg::SMOOTH_EN2_BIT];
    smooth_en[2] = smooth_cfg_23[fto_pkg::SMOOTH_EN3_BIT];
    step_code[0] =
      smoothing_and_floor_config[fto_pkg::STEP_CODE1_LSB +: 3];
    step_code[1] = smooth_cfg_23[fto_pkg::STEP_CODE2_LSB +: 3];
    step_code[2] = smooth_cfg_23[fto_pkg::STEP_CODE3_LSB +: 3];
  end

  // ==========================================================
  // critical override, one flag per temperature channel
  logic [2:0] next_crit_flag;

  always_comb begin
    next_crit_flag = crit_flag;
    for (int c = 0; c < 3; c++) begin
      // strict compare: a reading equal to the limit stays out
      if (temp_ch[c] > crit_limit[c]) begin
        next_crit_flag[c] = 1'b1;
      end else if (below_by(temp_ch[c], crit_limit[c],
                            fto_pkg::CRIT_RELEASE_HYST)) begin
        next_crit_flag[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      crit_flag <= 3'h0;
    end else begin
      crit_flag <= next_crit_flag;
    end
  end

  // no mask term exists anywhere on this path
  assign override_active = |crit_flag;

  // ==========================================================
  // turn-off hysteresis, per output since channel mapping may differ
  logic [2:0] next_running;

  always_comb begin
    next_running = running;
    for (int o = 0; o < 3; o++) begin
      // inside the band the flag holds, which stops chatter at start
      if (temp_ch[sel[o]] >= start_ch[sel[o]]) begin
        next_running[o] = 1'b1;
      end else if (below_by(temp_ch[sel[o]], start_ch[sel[o]],
                            {4'h0, hyst[sel[o]]})) begin
        next_running[o] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      running <= 3'h0;
    end else begin
      running <= next_running;
    end
  end

  // ==========================================================
  // policy target and smoothing
  logic [7:0] policy [3];
  logic [7:0] duty [3];
  logic [7:0] next_duty [3];

  always_comb begin
    for (int o = 0; o < 3; o++) begin
      // override is applied later, so no setting here can mask it
      if (floor_sel[o]) begin
        // floor outputs ignore the hysteresis band entirely
        if (temp_ch[sel[o]] < start_ch[sel[o]]) begin
          policy[o] = min_duty[o];
        end else begin
          policy[o] = target[o];
        end
      end else if (running[o]) begin
        policy[o] = target[o];
      end else begin
        policy[o] = fto_pkg::DUTY_OFF;
      end
    end
  end

  always_comb begin
    // smoothed outputs hold between duty_update pulses
    next_duty = duty;
    for (int o = 0; o < 3; o++) begin
      if (override_active) begin
        // also seeds the smoother so release ramps down from full
        next_duty[o] = fto_pkg::DUTY_FULL;
      end else if (!smooth_en[o]) begin
        next_duty[o] = policy[o];
      end else if (duty_update) begin
        next_duty[o] = step_toward(duty[o], policy[o],
                                   step_size(step_code[o]));
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int o = 0; o < 3; o++) begin
        duty[o] <= fto_pkg::DUTY_OFF;
      end
    end else begin
      duty <= next_duty;
    end
  end

  assign fan_drive_1 = duty[0];
  assign fan_drive_2 = duty[1];
  assign fan_drive_3 = duty[2];

endmodule

// ### bench/fto_fan_host.sv
// partner model: update source that pulses duty_update once per request
// assumes the bench raises kick for exactly one cycle
`timescale 1ns/1ns
module fto_fan_host (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic kick,
  output logic duty_update
);
  // ==========================================
  // one pulse per request
  logic next_duty_update;
  always_comb begin
    next_duty_update = kick && !duty_update;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      duty_update <= 1'b0;
    end else begin
      duty_update <= next_duty_update;
    end
  end
endmodule

// ### bench/fto_props.sv
// assertions on the fto_policy ports
// assumes limits change only through the register port
`timescale 1ns/1ns
module fto_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_local,
  input wire logic [7:0] temp_remote2,
  input wire logic [7:0] fan_drive_1,
  input wire logic [7:0] fan_drive_2,
  input wire logic [7:0] fan_drive_3,
  input wire logic override_active
);
  // ==========================================
  // limit mirror snooped from writes
  logic [7:0] lim [3];
  logic [7:0] next_lim [3];
  logic hot, cool, rest_cool, band1;
  always_comb begin
    next_lim = lim;
    for (int i = 0; i < 3; i++) begin
      if (reg_wr && reg_addr == 8'h6A + 8'(i)) begin
        next_lim[i] = reg_wdata;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lim <= '{3{8'h64}};
    end else begin
      lim <= next_lim;
    end
  end
  // release math wraps below 4, so limits stay at 4 or more
  assign hot = temp_remote1 > lim[0] || temp_local > lim[1]
    || temp_remote2 > lim[2];
  assign rest_cool = temp_local < lim[1] - 8'h04
    && temp_remote2 < lim[2] - 8'h04;
  assign band1 = temp_remote1 >= lim[0] - 8'h04;
  assign cool = rest_cool && !band1;
  // ==========================================
  // properties
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  over_set_a: assert property (hot |=> override_active)
    else $error("override not raised above limit");
  over_full_a: assert property (
    override_active |=> fan_drive_1 == 8'hFF && fan_drive_2 == 8'hFF
    && fan_drive_3 == 8'hFF)
    else $error("drives not full under override");
  over_hold_a: assert property (
    override_active && band1 && rest_cool && $past(rest_cool)
    |=> override_active)
    else $error("override dropped inside release band");
  over_drop_a: assert property (cool |=> !override_active)
    else $error("override kept below release point");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  stat_rd_a: assert property (
    reg_rd && reg_addr == 8'h71 |=> reg_rdata[0] == $past(override_active))
    else $error("status override bit wrong");
  stat_flag_a: assert property (
    reg_rd && reg_addr == 8'h71 |=> (|reg_rdata[3:1]) == reg_rdata[0])
    else $error("status flags disagree with override");
  hyst2_rd_a: assert property (
    reg_rd && reg_addr == 8'h6E |=> reg_rdata[3:0] == 4'h0)
    else $error("unused hysteresis nibble not zero");
endmodule
bind fto_policy fto_props u_fto_props (
  .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .temp_remote1, .temp_local, .temp_remote2,
  .fan_drive_1, .fan_drive_2, .fan_drive_3, .override_active
);

// ### bench/fto_policy_tb_top.sv
// bench for fto_policy: register tasks and thermal/duty sequences
// assumes outputs 1 and 3 follow remote 1 through chan_sel 0, while output 2 follows cs2
`timescale 1ns/1ns
module fto_policy_tb_top;
  // ==========================================
  // stimulus, outputs and counters
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, kick = 1'b0;
  logic duty_update;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] temp_remote1 = 8'h14, tl = 8'h14, st = 8'h1E, mn = 8'h40;
  logic [7:0] g1 = 8'h80, g2 = 8'h80, g3 = 8'h80, d1, d2, d3;
  logic [1:0] cs2 = 2'h0;
  logic [7:0] ra [8] = '{8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h62, 8'h63,
    8'h00};
  logic [7:0] rv [8] = '{8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00,
    8'h00};
  logic [7:0] stp [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18,
    8'h30};
  int n_fail = 0;
  int tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  fto_fan_host u_fto_fan_host (.ref_clk, .nrst, .kick, .duty_update);
  fto_policy u_fto_policy (
    .ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .temp_remote1, .temp_local(tl), .temp_remote2(tl),
    .start_temp_remote1(st), .start_temp_local(st),
    .start_temp_remote2(st), .chan_sel_1(2'h0), .chan_sel_2(cs2),
    .chan_sel_3(2'h0), .minimum_fan_duty_1(mn), .minimum_fan_duty_2(mn),
    .minimum_fan_duty_3(mn), .target_duty_1(g1), .target_duty_2(g2),
    .target_duty_3(g3), .duty_update, .fan_drive_1(d1), .fan_drive_2(d2),
    .fan_drive_3(d3), .override_active()
  );
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic dchk(input logic [7:0] e1, e2, e3);
    #1 chk("fan_drive_1", e1, d1);
    chk("fan_drive_2", e2, d2);
    chk("fan_drive_3", e3, d3);
  endtask
  task automatic tstep(input logic [7:0] v, e);
    @(posedge ref_clk);
    temp_remote1 <= v;
    repeat (3) @(posedge ref_clk);
    dchk(e, e, e);
  endtask
  task automatic lstep(input logic [1:0] s, input logic [7:0] v, o, e);
    @(posedge ref_clk);
    cs2 <= s;
    tl <= v;
    repeat (3) @(posedge ref_clk);
    dchk(o, e, o);
  endtask
  task automatic tick;
    @(posedge ref_clk);
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================
  // sequences
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h6A, 8'h50);
    rd(8'h6A, 8'h50);
    wr(8'h6A, 8'h64);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    tstep(8'h14, 8'h00);
    tstep(8'h1E, 8'h80);
    tstep(8'h1B, 8'h80);
    tstep(8'h19, 8'h00);
    wr(8'h62, 8'hE0);
    tstep(8'h19, 8'h40);
    tstep(8'h1E, 8'h80);
    tstep(8'h1D, 8'h40);
    wr(8'h62, 8'h00);
    wr(8'h6D, 8'h14);
    tstep(8'h1E, 8'h80);
    tstep(8'h1D, 8'h80);
    tstep(8'h1C, 8'h00);
    lstep(2'h1, 8'h1E, 8'h00, 8'h80);
    lstep(2'h1, 8'h1B, 8'h00, 8'h80);
    lstep(2'h1, 8'h19, 8'h00, 8'h00);
    lstep(2'h0, 8'h14, 8'h00, 8'h00);
    tstep(8'h65, 8'hFF);
    rd(8'h71, 8'h73);
    tstep(8'h61, 8'hFF);
    tstep(8'h5F, 8'h80);
    lstep(2'h0, 8'h65, 8'hFF, 8'hFF);
    rd(8'h71, 8'h7D);
    lstep(2'h0, 8'h14, 8'h80, 8'h80);
    // override parks the smoothers at full, a known start point
    for (int c = 0; c < 8; c++) begin
      wr(8'h62, 8'h08 | c[7:0]);
      wr(8'h63, 8'h08 | c[7:0]);
      tstep(8'h70, 8'hFF);
      @(posedge ref_clk);
      temp_remote1 <= 8'h50;
      repeat (3) @(posedge ref_clk);
      dchk(8'hFF, 8'h80, 8'hFF);
      tick;
      dchk(8'hFF - stp[c], 8'h80, 8'hFF - stp[c]);
    end
    @(posedge ref_clk);
    g1 <= 8'hE0;
    g2 <= 8'h20;
    repeat (3) @(posedge ref_clk);
    dchk(8'hCF, 8'h20, 8'hCF);
    tick;
    dchk(8'hE0, 8'h20, 8'h9F);
    final_report();
  end
endmodule
